// [hdl/fsl_pkg.sv]
// package: fault status bank register map, layouts and carriers
// Summary of operation
// - latched flags stay set after fault clears
// - read clears latched bit only if fault gone
// - latched bit sets on live rising edge only
// - fault bits read one when faulted; read-only
// - one bit7: supply off until restart
// - one bit6: ored switch gate off
// - one bit5: primary power-good aggregate
// - one bit4: maskable secondary power-good aggregate
// - one bit3: rectifiers disabled by user/load/flag
// - one bits2..0: fast, accurate one, accurate two
// - two bit7: sense continuity difference above limit
// - two bit6: local sense undervoltage
// - two bit5: ored switch reverse voltage
// - two bits4,3: supply under, core over shutdown
// - two bit2: supply over needs request toggle
// - two bits1,0: load and local overvoltage
package fsl_pkg;

  // register offsets
  localparam logic [7:0] ADDR_LIVE_ONE = 8'h00;
  localparam logic [7:0] ADDR_LIVE_TWO = 8'h01;
  localparam logic [7:0] ADDR_LIVE_THREE = 8'h02;
  localparam logic [7:0] ADDR_LIVE_FOUR = 8'h03;
  localparam logic [7:0] ADDR_LATCH_ONE = 8'h04;
  localparam logic [7:0] ADDR_LATCH_TWO = 8'h05;
  localparam logic [7:0] ADDR_LATCH_THREE = 8'h06;
  localparam logic [7:0] ADDR_LATCH_FOUR = 8'h07;
  localparam logic [7:0] ADDR_MASK_LO = 8'h10;
  localparam logic [7:0] ADDR_MASK_MID = 8'h11;
  localparam logic [7:0] ADDR_MASK_HI = 8'h12;

  // bus address default, arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;
  localparam logic [6:0] DEV_ADDR_RESERVED_TOP = 7'h07;

  localparam int NUM_LATCHED = 4;
  localparam int PG2_FLAGS = 17;
  localparam logic [PG2_FLAGS-1:0] MASK_RESET = 17'h0_0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT = 4'h1;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // bit positions inside the pass-through registers three and four
  localparam int THREE_OVER_TEMP = 7;
  localparam int THREE_EXT_FLAG = 0;
  localparam int FOUR_LINE_SENSE = 2;
  localparam int FOUR_CRC = 1;
  localparam int FOUR_UNLOCKED = 0;

  // layout of live and latched register one, msb first
  typedef struct packed {
    logic supply_off;
    logic ored_off;
    logic pg_primary;
    logic pg_secondary;
    logic rect_off;
    logic fast_oc_one;
    logic acc_oc_one;
    logic acc_oc_two;
  } fsl_stat_one_t;

  // layout of live and latched register two, msb first
  typedef struct packed {
    logic continuity;
    logic under_volt;
    logic ored_reverse;
    logic supply_under;
    logic core_over;
    logic supply_over;
    logic load_over;
    logic local_over;
  } fsl_stat_two_t;

  // raw conditions from comparators and neighbouring logic
  typedef struct packed {
    logic fast_oc_one;
    logic acc_oc_one;
    logic acc_oc_two;
    logic ored_off;
    logic continuity;
    logic under_volt;
    logic ored_reverse;
    logic supply_under;
    logic core_over;
    logic supply_over;
    logic load_over;
    logic local_over;
    logic rect_user_off;
    logic light_load;
    logic rect_flag_off;
    logic power_on_request;
    logic [7:0] status_three;
    logic [7:0] status_four;
  } fsl_fault_in_t;

  typedef enum logic [2:0] {
    FSL_IDLE = 3'b000,
    FSL_RX = 3'b001,
    FSL_RX_ACK = 3'b010,
    FSL_TX = 3'b011,
    FSL_TX_ACK = 3'b100
  } fsl_i2c_state_t;

endpackage : fsl_pkg

// [hdl/fsl_latch_byte.sv]
// module: one latched fault register, rising-edge set, conditional read clear
module fsl_latch_byte #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] live,
  input wire logic read_clear,
  output logic [WIDTH-1:0] latched
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] latched_reg;
  logic [WIDTH-1:0] rise;

  if (WIDTH < 1) begin : g_bad_width
    $error("fsl_latch_byte: width must be positive");
  end

  // only a normal-to-fault step sets, a standing level does not
  assign rise = live & ~prev_reg;
  assign latched = latched_reg;

  // previous live value for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= live;
    end
  end

  // a rise in the clear cycle still sets, so no event is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latched_reg <= '0;
    end else if (read_clear) begin
      latched_reg <= (latched_reg & live) | rise;
    end else begin
      latched_reg <= latched_reg | rise;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_LATCH_HOLDS: assert property (!read_clear |=> (latched_reg & $past(latched_reg)) == $past(latched_reg))
    else $error("latched bit dropped without a read");
  AST_CLEAR_ONLY_IF_GONE: assert property (read_clear |=>
    latched_reg == (($past(latched_reg) & $past(live)) | $past(rise)))
    else $error("latched bit cleared while fault present");
  // a fresh rise on an already latched bit adds nothing new
  AST_SET_ON_RISE_ONLY: assert property (1'b1 |=>
    (latched_reg & ~$past(latched_reg)) == ($past(rise) & ~$past(latched_reg)))
    else $error("latched bit set without a rising edge");
  CVR_CLEARED_BY_READ: cover property (latched_reg != '0 ##0 read_clear ##1 latched_reg == '0);

endmodule : fsl_latch_byte

// [hdl/fsl_bank.sv]
// module: fault status bank with live and latched registers behind an i2c slave
module fsl_bank #(
  parameter logic [6:0] DEV_ADDR = fsl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fsl_pkg::fsl_fault_in_t fault_in,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic supply_off,
  output logic power_good_primary_fault,
  output logic power_good_secondary_fault,
  output logic rectifiers_disabled
);

  if (DEV_ADDR <= fsl_pkg::DEV_ADDR_RESERVED_TOP) begin : g_bad_addr
    $error("fsl_bank: bus address falls in the reserved range");
  end

  fsl_pkg::fsl_fault_in_t meta_reg;
  fsl_pkg::fsl_fault_in_t sync_reg;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic pon_prev_reg;
  logic lockout_reg;
  logic supply_off_reg;
  fsl_pkg::fsl_stat_one_t live_one_reg;
  fsl_pkg::fsl_stat_two_t live_two_reg;
  logic [7:0] live_three_reg;
  logic [7:0] live_four_reg;
  logic [fsl_pkg::PG2_FLAGS-1:0] mask_reg;
  logic [fsl_pkg::PG2_FLAGS-1:0] pg2_flags;
  fsl_pkg::fsl_stat_one_t live_one_next;
  fsl_pkg::fsl_stat_two_t live_two_next;
  logic [7:0] live_bytes [fsl_pkg::NUM_LATCHED];
  logic [7:0] latched_bytes [fsl_pkg::NUM_LATCHED];
  logic [fsl_pkg::NUM_LATCHED-1:0] read_clear_reg;
  fsl_pkg::fsl_i2c_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic first_byte_reg;
  logic ptr_valid_reg;
  logic rw_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic wr_strobe_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic load_strobe_reg;
  logic [7:0] load_addr_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic pon_fall;
  logic [7:0] rd_data;

  // two flops on every fault input (bus pins get three, below); stage 0 feeds stage 1 only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= fault_in;
      sync_reg <= meta_reg;
    end
  end

  // bus pins: stages 1 and 2 are compared for edges, never stage 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
    end
  end

  assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign bus_start = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_sync_reg[1];
  assign bus_stop = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_sync_reg[1];
  assign pon_fall = pon_prev_reg & ~sync_reg.power_on_request;

  // supply over-voltage locks the supply off until the request pin toggles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pon_prev_reg <= 1'b0;
      lockout_reg <= 1'b0;
    end else begin
      pon_prev_reg <= sync_reg.power_on_request;
      if (sync_reg.supply_over) begin
        lockout_reg <= 1'b1;
      end else if (pon_fall) begin
        lockout_reg <= 1'b0;
      end
    end
  end

  // supply held off until requested and every shutdown cause is gone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_off_reg <= 1'b1;
    end else begin
      supply_off_reg <= ~sync_reg.power_on_request | sync_reg.supply_under | sync_reg.core_over
        | sync_reg.supply_over | lockout_reg;
    end
  end

  // secondary power-good sources; a set mask bit drops that source
  assign pg2_flags = {supply_off_reg, sync_reg.ored_off, sync_reg.fast_oc_one, sync_reg.acc_oc_one,
    sync_reg.acc_oc_two, sync_reg.continuity, sync_reg.under_volt, sync_reg.ored_reverse,
    sync_reg.status_four[fsl_pkg::FOUR_LINE_SENSE], sync_reg.status_three[fsl_pkg::THREE_EXT_FLAG],
    sync_reg.core_over, sync_reg.supply_over, sync_reg.local_over, sync_reg.load_over,
    sync_reg.status_three[fsl_pkg::THREE_OVER_TEMP], sync_reg.status_four[fsl_pkg::FOUR_CRC],
    sync_reg.status_four[fsl_pkg::FOUR_UNLOCKED]};

  // next live values, one to a bit, same layout reused by the latches
  always_comb begin
    live_one_next.supply_off = supply_off_reg;
    live_one_next.ored_off = sync_reg.ored_off;
    live_one_next.pg_primary = supply_off_reg | sync_reg.fast_oc_one | sync_reg.acc_oc_one
      | sync_reg.acc_oc_two | sync_reg.under_volt | sync_reg.local_over | sync_reg.load_over;
    live_one_next.pg_secondary = |(pg2_flags & ~mask_reg);
    live_one_next.rect_off = sync_reg.rect_user_off | sync_reg.light_load | sync_reg.rect_flag_off;
    live_one_next.fast_oc_one = sync_reg.fast_oc_one;
    live_one_next.acc_oc_one = sync_reg.acc_oc_one;
    live_one_next.acc_oc_two = sync_reg.acc_oc_two;
    live_two_next.continuity = sync_reg.continuity;
    live_two_next.under_volt = sync_reg.under_volt;
    live_two_next.ored_reverse = sync_reg.ored_reverse;
    live_two_next.supply_under = sync_reg.supply_under;
    live_two_next.core_over = sync_reg.core_over;
    live_two_next.supply_over = sync_reg.supply_over;
    live_two_next.load_over = sync_reg.load_over;
    live_two_next.local_over = sync_reg.local_over;
  end

  // live registers track conditions every cycle, no memory
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      live_one_reg <= '0;
      live_two_reg <= '0;
      live_three_reg <= '0;
      live_four_reg <= '0;
    end else begin
      live_one_reg <= live_one_next;
      live_two_reg <= live_two_next;
      live_three_reg <= sync_reg.status_three;
      live_four_reg <= sync_reg.status_four;
    end
  end

  assign live_bytes[0] = live_one_reg;
  assign live_bytes[1] = live_two_reg;
  assign live_bytes[2] = live_three_reg;
  assign live_bytes[3] = live_four_reg;

  // one latch per live register, identical layout
  for (genvar i = 0; i < fsl_pkg::NUM_LATCHED; i++) begin : g_latch
    fsl_latch_byte #(.WIDTH(8)) u_latch (
      .clk(clk),
      .sys_rst(sys_rst),
      .live(live_bytes[i]),
      .read_clear(read_clear_reg[i]),
      .latched(latched_bytes[i])
    );
  end

  // clear fires the cycle after the byte sits in the shifter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_clear_reg <= '0;
    end else begin
      for (int i = 0; i < fsl_pkg::NUM_LATCHED; i++) begin
        read_clear_reg[i] <= load_strobe_reg && (load_addr_reg == fsl_pkg::ADDR_LATCH_ONE + 8'(i));
      end
    end
  end

  // read data; fault registers only ever come from hardware
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] data;
    data = fsl_pkg::READ_UNMAPPED;
    case (addr)
      fsl_pkg::ADDR_LIVE_ONE: data = live_bytes[0];
      fsl_pkg::ADDR_LIVE_TWO: data = live_bytes[1];
      fsl_pkg::ADDR_LIVE_THREE: data = live_bytes[2];
      fsl_pkg::ADDR_LIVE_FOUR: data = live_bytes[3];
      fsl_pkg::ADDR_LATCH_ONE: data = latched_bytes[0];
      fsl_pkg::ADDR_LATCH_TWO: data = latched_bytes[1];
      fsl_pkg::ADDR_LATCH_THREE: data = latched_bytes[2];
      fsl_pkg::ADDR_LATCH_FOUR: data = latched_bytes[3];
      fsl_pkg::ADDR_MASK_LO: data = mask_reg[7:0];
      fsl_pkg::ADDR_MASK_MID: data = mask_reg[15:8];
      fsl_pkg::ADDR_MASK_HI: data = {7'h00, mask_reg[16]};
      default: data = fsl_pkg::READ_UNMAPPED;
    endcase
    return data;
  endfunction : read_byte

  // byte at the pointer, so its msb can be put on the line at load time
  always_comb begin
    rd_data = read_byte(ptr_reg);
  end

  // mask is the only writable state; writes elsewhere are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_reg <= fsl_pkg::MASK_RESET;
    end else if (wr_strobe_reg) begin
      case (wr_addr_reg)
        fsl_pkg::ADDR_MASK_LO: mask_reg[7:0] <= wr_data_reg;
        fsl_pkg::ADDR_MASK_MID: mask_reg[15:8] <= wr_data_reg;
        fsl_pkg::ADDR_MASK_HI: mask_reg[16] <= wr_data_reg[0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // i2c slave: address, pointer, then data bytes with auto-increment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= fsl_pkg::FSL_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      ptr_reg <= '0;
      first_byte_reg <= 1'b0;
      ptr_valid_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      load_strobe_reg <= 1'b0;
      load_addr_reg <= '0;
    end else begin
      wr_strobe_reg <= 1'b0;
      load_strobe_reg <= 1'b0;
      if (bus_stop) begin
        state_reg <= fsl_pkg::FSL_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (bus_start) begin
        state_reg <= fsl_pkg::FSL_RX;
        bit_cnt_reg <= '0;
        first_byte_reg <= 1'b1;
        ptr_valid_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          fsl_pkg::FSL_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          fsl_pkg::FSL_RX: begin
            if (scl_rise && bit_cnt_reg != fsl_pkg::BITS_PER_BYTE) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == fsl_pkg::BITS_PER_BYTE) begin
              if (first_byte_reg) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  sda_oe_reg <= 1'b1;
                  state_reg <= fsl_pkg::FSL_RX_ACK;
                end else begin
                  state_reg <= fsl_pkg::FSL_IDLE;
                end
              end else if (!ptr_valid_reg) begin
                ptr_reg <= shift_reg;
                ptr_valid_reg <= 1'b1;
                sda_oe_reg <= 1'b1;
                state_reg <= fsl_pkg::FSL_RX_ACK;
              end else begin
                wr_strobe_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                sda_oe_reg <= 1'b1;
                state_reg <= fsl_pkg::FSL_RX_ACK;
              end
            end
          end
          fsl_pkg::FSL_RX_ACK: begin
            if (scl_fall) begin
              first_byte_reg <= 1'b0;
              if (first_byte_reg && rw_reg) begin
                shift_reg <= rd_data;
                sda_oe_reg <= ~rd_data[7];
                bit_cnt_reg <= fsl_pkg::FIRST_TX_BIT;
                load_strobe_reg <= 1'b1;
                load_addr_reg <= ptr_reg;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= fsl_pkg::FSL_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                bit_cnt_reg <= '0;
                state_reg <= fsl_pkg::FSL_RX;
              end
            end
          end
          fsl_pkg::FSL_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == fsl_pkg::BITS_PER_BYTE) begin
                sda_oe_reg <= 1'b0;
                state_reg <= fsl_pkg::FSL_TX_ACK;
              end else begin
                sda_oe_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          fsl_pkg::FSL_TX_ACK: begin
            if (scl_rise && sda_sync_reg[1]) begin
              state_reg <= fsl_pkg::FSL_IDLE;
            end else if (scl_fall) begin
              shift_reg <= rd_data;
              sda_oe_reg <= ~rd_data[7];
              bit_cnt_reg <= fsl_pkg::FIRST_TX_BIT;
              load_strobe_reg <= 1'b1;
              load_addr_reg <= ptr_reg;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= fsl_pkg::FSL_TX;
            end
          end
          default: begin
            state_reg <= fsl_pkg::FSL_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign supply_off = live_one_reg.supply_off;
  assign power_good_primary_fault = live_one_reg.pg_primary;
  assign power_good_secondary_fault = live_one_reg.pg_secondary;
  assign rectifiers_disabled = live_one_reg.rect_off;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SUPPLY_OFF_LOCKED: assert property (lockout_reg |=> supply_off_reg ##1 supply_off)
    else $error("supply bit clear while locked out");
  AST_ORED_BIT: assert property (1'b1 |=> live_one_reg.ored_off == $past(sync_reg.ored_off))
    else $error("ored switch bit does not follow its condition");
  AST_PG_PRIMARY: assert property (sync_reg.fast_oc_one |=> power_good_primary_fault)
    else $error("primary power-good missed fast overcurrent");
  AST_PG_MASKED: assert property ((&mask_reg) |=> !power_good_secondary_fault)
    else $error("fully masked secondary power-good still set");
  AST_RECT_OFF: assert property ((sync_reg.rect_user_off || sync_reg.light_load) |=> rectifiers_disabled)
    else $error("rectifier off bit missing");
  AST_OC_BITS: assert property (1'b1 |=> live_one_reg[2:0] ==
    $past({sync_reg.fast_oc_one, sync_reg.acc_oc_one, sync_reg.acc_oc_two}))
    else $error("overcurrent bits out of order");
  AST_SHUTDOWN: assert property ((sync_reg.core_over || sync_reg.supply_under) |=> ##1 supply_off)
    else $error("no shutdown on core or supply fault");
  AST_LOCK_NEEDS_TOGGLE: assert property (lockout_reg && sync_reg.power_on_request |=> lockout_reg)
    else $error("lockout released without request toggle");
  AST_LIVE_TWO: assert property (1'b1 |=> live_two_reg == $past(live_two_next))
    else $error("live register two lags or latches");
  AST_CLEAR_AFTER_LOAD: assert property (load_strobe_reg && load_addr_reg == fsl_pkg::ADDR_LATCH_ONE
    |-> !read_clear_reg[0] ##1 read_clear_reg[0])
    else $error("clear not one cycle after byte capture");
  AST_READ_ONLY: assert property (wr_strobe_reg && wr_addr_reg < fsl_pkg::ADDR_MASK_LO |=> $stable(mask_reg))
    else $error("write to fault register changed state");

  CVR_ADDR_ACK: cover property (state_reg == fsl_pkg::FSL_RX_ACK && first_byte_reg);
  CVR_LATCH_READ: cover property (read_clear_reg[1]);
  CVR_LOCKOUT_TOGGLE: cover property (lockout_reg ##1 !lockout_reg);
  CVR_PG_SECONDARY: cover property (power_good_secondary_fault && !power_good_primary_fault);

endmodule : fsl_bank

// [tb/fsl_host.sv]
// bus host model that reads and writes the fault bank registers
module fsl_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // one scl phase, well above the device's input sync delay
  task automatic ph();
    repeat (8) @(posedge clk);
    #1;
  endtask : ph

  // data moves a few clocks after scl falls, never with it
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge clk);
    #1;
    sda_drv = b;
    ph();
    scl = 1'b1;
    ph();
    r = sda_in;
    scl = 1'b0;
  endtask : bit_io

  // eight bits msb first, then the ninth bit is left to the device
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io

  task automatic start();
    repeat (3) @(posedge clk);
    #1;
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    repeat (3) @(posedge clk);
    #1;
    sda_drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b1;
    ph();
  endtask : stop

  // one-byte write, or pointer then repeated start and one-byte read
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rdata, output logic ok);
    logic [7:0] x;
    logic a1, a2, a3, a4;
    rdata = 8'h00;
    start();
    byte_io({dev, 1'b0}, x, a1);
    byte_io(ptr, x, a2);
    if (wr) begin
      byte_io(wd, x, a3);
    end else begin
      start();
      byte_io({dev, 1'b1}, x, a3);
      byte_io(8'hff, rdata, a4); // last byte: host answers nack
    end
    stop();
    ok = a1 & a2 & a3;
  endtask : xfer
endmodule : fsl_host

// [tb/fsl_bank_tb.sv]
// self-checking bench for the fault status bank
module fsl_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, scl, sda_drv, sda_o, sda_oe, sda, so, pg1, pg2, rof, ok;
  fsl_pkg::fsl_fault_in_t fi, f;
  logic [7:0] d, e1, e2;
  int n_errors, checks, cyc;

  // open-drain data line with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & sda_drv;

  fsl_bank uut (.clk(clk), .sys_rst(sys_rst), .fault_in(fi), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .supply_off(so), .power_good_primary_fault(pg1), .power_good_secondary_fault(pg2),
    .rectifiers_disabled(rof));
  fsl_host host (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cycle ceiling; bus reads take most of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      $display("BAD %0t run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a);
    host.xfer(fsl_pkg::DEV_ADDR_DEFAULT, a, 1'b0, 8'h00, d, ok);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk({7'h00, ok}, 8'h01, "ack");
    chk(d, e, $sformatf("reg %h", a));
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.xfer(fsl_pkg::DEV_ADDR_DEFAULT, a, 1'b1, v, d, ok);
  endtask : wr

  // sync, live register and supply state all land well inside this wait
  task automatic settle();
    fi = f;
    repeat (8) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_one(input fsl_pkg::fsl_fault_in_t x);
    logic s, p1, p2;
    s = x.supply_under | x.core_over | x.supply_over | ~x.power_on_request;
    p1 = s | x.fast_oc_one | x.acc_oc_one | x.acc_oc_two | x.under_volt | x.local_over | x.load_over;
    p2 = p1 | x.ored_off | x.continuity | x.ored_reverse | x.status_three[7] | x.status_three[0] | (|x.status_four[2:0]);
    return {s, x.ored_off, p1, p2, x.rect_user_off | x.light_load | x.rect_flag_off, x.fast_oc_one,
            x.acc_oc_one, x.acc_oc_two};
  endfunction : exp_one

  function automatic logic [7:0] exp_two(input fsl_pkg::fsl_fault_in_t x);
    return {x.continuity, x.under_volt, x.ored_reverse, x.supply_under, x.core_over, x.supply_over,
            x.load_over, x.local_over};
  endfunction : exp_two

  initial begin
    sys_rst = 1'b1;
    f = '0;
    f.power_on_request = 1'b1;
    fi = f;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(56));
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    settle();
    // start-up supply-off edge latches; first read clears, reread confirms
    for (int a = 4; a < 8; a++) begin
      rd(a[7:0]);
      rdc(a[7:0], 8'h00);
    end
    $display("test flush done");
    // random faults with the supply held on (shutdown causes tested apart)
    for (int k = 0; k < 5; k++) begin
      f = fsl_pkg::fsl_fault_in_t'($urandom);
      f.power_on_request = 1'b1;
      f.supply_under = 1'b0;
      f.core_over = 1'b0;
      f.supply_over = 1'b0;
      settle();
      e1 = exp_one(f);
      e2 = exp_two(f);
      chk({4'h0, so, pg1, pg2, rof}, {4'h0, e1[7], e1[5], e1[4], e1[3]}, "pins");
      rdc(fsl_pkg::ADDR_LIVE_ONE, e1);
      rdc(fsl_pkg::ADDR_LIVE_TWO, e2);
      d = f.status_three;
      f = '0;
      f.power_on_request = 1'b1;
      settle();
      rdc(fsl_pkg::ADDR_LATCH_ONE, e1);
      rdc(fsl_pkg::ADDR_LATCH_TWO, e2);
      rd(fsl_pkg::ADDR_LATCH_THREE);
      rdc(fsl_pkg::ADDR_LATCH_ONE, 8'h00);
      rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h00);
    end
    $display("test random done");
    // fault still present at read keeps the latch
    f.continuity = 1'b1;
    settle();
    rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h80);
    rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h80);
    f.continuity = 1'b0;
    settle();
    rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h80);
    rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h00);
    $display("test held fault done");
    // full exclusion mask, write to a read-only register dropped
    wr(fsl_pkg::ADDR_MASK_LO, 8'hff);
    wr(fsl_pkg::ADDR_MASK_MID, 8'hff);
    wr(fsl_pkg::ADDR_MASK_HI, 8'h01);
    wr(fsl_pkg::ADDR_LIVE_ONE, 8'hff);
    f.ored_off = 1'b1;
    settle();
    chk({7'h00, pg2}, 8'h00, "masked pg2");
    rdc(fsl_pkg::ADDR_LIVE_ONE, 8'h40);
    wr(fsl_pkg::ADDR_MASK_LO, 8'h00);
    wr(fsl_pkg::ADDR_MASK_MID, 8'h00);
    wr(fsl_pkg::ADDR_MASK_HI, 8'h00);
    rdc(fsl_pkg::ADDR_LIVE_ONE, 8'h50);
    f.ored_off = 1'b0;
    settle();
    rdc(fsl_pkg::ADDR_LATCH_ONE, 8'h50);
    rdc(fsl_pkg::ADDR_LATCH_ONE, 8'h00);
    $display("test mask done");
    // immediate shutdown causes follow their level
    for (int i = 0; i < 2; i++) begin
      f.supply_under = (i == 0);
      f.core_over = (i == 1);
      settle();
      chk({7'h00, so}, 8'h01, "shutdown");
      f.supply_under = 1'b0;
      f.core_over = 1'b0;
      settle();
      chk({7'h00, so}, 8'h00, "restart");
    end
    // supply over locks out until the request toggles
    f.supply_over = 1'b1;
    settle();
    f.supply_over = 1'b0;
    settle();
    chk({7'h00, so}, 8'h01, "lockout");
    rdc(fsl_pkg::ADDR_LIVE_ONE, 8'hb0);
    f.power_on_request = 1'b0;
    settle();
    f.power_on_request = 1'b1;
    settle();
    chk({7'h00, so}, 8'h00, "toggle");
    rd(fsl_pkg::ADDR_LATCH_TWO);
    rdc(fsl_pkg::ADDR_LATCH_TWO, 8'h00);
    $display("test supply done");
    rdc(8'h20, fsl_pkg::READ_UNMAPPED);
    host.xfer(fsl_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 8'h00, 1'b0, 8'h00, d, ok);
    chk({7'h00, ok}, 8'h00, "foreign address");
    $display("test refusals done");
    complete_run();
  end
endmodule : fsl_bank_tb
